/* asw_pkg.sv */
// Shared constants, register layouts and helpers for the converter sequencer
package asw_pkg;
  // Timing, system clock of 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_MIN_NS = 200;
  localparam int WAKE_ADC_NS = 1000;
  localparam int WAKE_REF_NS = 2000;
  localparam logic [15:0] SAMPLE_MIN_CYC = 16'((SAMPLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] WAKE_ADC_CYC = 16'((WAKE_ADC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] WAKE_REF_CYC = 16'((WAKE_REF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CONV_CLKS_12 = 8'h0d;
  localparam logic [7:0] CONV_CLKS_14 = 8'h0f;

  // Register byte addresses
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_SAMPLE = 8'h0c;
  localparam logic [7:0] ADDR_UPPER = 8'h10;
  localparam logic [7:0] ADDR_LOWER = 8'h14;
  localparam logic [7:0] ADDR_RESULT = 8'h18;
  localparam logic [7:0] ADDR_OFFSET = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Field widths and codes
  localparam int BYTE_W = 8;
  localparam int SAMP_W = 8;
  localparam int OFFSET_W = 14;
  localparam int DATA_W = 16;
  localparam logic [1:0] START_IDLE = 2'h0;
  localparam logic [1:0] START_CONV = 2'h1;
  localparam logic [1:0] START_OFFCAL = 2'h2;
  localparam logic [1:0] START_GAINCAL = 2'h3;
  localparam logic [1:0] PWR_AUTO = 2'h0;
  localparam logic [1:0] PWR_ON = 2'h2;
  localparam logic [15:0] MASK12 = 16'h0fff;
  localparam logic [15:0] MASK14 = 16'h3fff;
  localparam int SHIFT12 = 4;
  localparam int SHIFT14 = 2;
  localparam int DROP12 = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_SAMPLE, ST_CONVERT} asw_state_e;

  typedef struct packed {
    logic [27:0] zero;
    logic cont_sel;
    logic irq_sel;
    logic [1:0] start;
  } asw_ctrl0_s;

  typedef struct packed {
    logic [27:0] zero;
    logic input_mode_select;
    logic signed_format_select;
    logic resolution_select;
    logic result_alignment_select;
  } asw_ctrl1_s;

  typedef struct packed {
    logic [25:0] zero;
    logic ref_buf_auto;
    logic [1:0] power_control_reg;
    logic [2:0] clock_divisor_select;
  } asw_ctrl2_s;

  typedef struct packed {
    logic [26:0] zero;
    logic busy;
    logic core_pwr;
    logic eoc;
    logic win;
    logic pend;
  } asw_status_s;

  // Controls toward the analog core
  typedef struct packed {
    logic pwr;
    logic ref_buf;
    logic sample;
    logic convert;
    logic [1:0] op;
  } asw_core_s;

  // Byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
    end
    return m;
  endfunction

  // Places a 14-bit value into result format
  function automatic logic [15:0] format_result(input logic [13:0] v, input asw_ctrl1_s f);
    logic [15:0] x;
    x = f.resolution_select ? 16'(v) : 16'(v >> DROP12);
    if (f.result_alignment_select) x = f.resolution_select ? (x << SHIFT14) : (x << SHIFT12);
    return x;
  endfunction

  // Extracts the live bits of a result-format word as a signed number
  function automatic logic signed [16:0] field_value(input logic [15:0] v, input asw_ctrl1_s f);
    logic [15:0] s;
    logic [15:0] m;
    m = f.resolution_select ? MASK14 : MASK12;
    s = v;
    if (f.result_alignment_select) s = f.resolution_select ? (v >> SHIFT14) : (v >> SHIFT12);
    s = s & m;
    if (f.signed_format_select && ((s & (m ^ (m >> 1))) != 16'h0)) s = s | ~m;
    return f.signed_format_select ? {s[15], s} : {1'b0, s};
  endfunction
endpackage

/* asw_prescaler.sv */
// Converter clock divider from the system clock
`timescale 1ns/1ns
module asw_prescaler
  import asw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic run_i,
  input wire logic [2:0] div_sel_i,
  // Divided clock
  output logic adc_clk_o,
  output logic tick_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic clk;
  } asw_div_s;

  asw_div_s r;
  asw_div_s n;
  logic [7:0] half;

  // Half period of 1 << select, so divisor is 2 << select
  assign half = 8'h01 << div_sel_i;
  assign tick_o = run_i && (r.cnt == half - 8'h01) && !r.clk;
  assign adc_clk_o = r.clk;

  // Toggle the divided clock every half period
  always_comb begin
    n = r;
    if (!run_i) begin
      n.cnt = 8'h00;
      n.clk = 1'b0;
    end else if (r.cnt == half - 8'h01) begin
      n.cnt = 8'h00;
      n.clk = !r.clk;
    end else begin
      n.cnt = r.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

/* asw_window.sv */
// Window comparator on result-format words
`timescale 1ns/1ns
module asw_window
  import asw_pkg::*;
(
  // Operands
  input wire logic [15:0] value_i,
  input wire logic [15:0] upper_i,
  input wire logic [15:0] lower_i,
  input wire asw_ctrl1_s fmt_i,
  // Verdict
  output logic outside_o
);
  logic signed [16:0] v;
  logic signed [16:0] u;
  logic signed [16:0] l;

  // Same format for all three, reserved bits masked off
  assign v = field_value(value_i, fmt_i);
  assign u = field_value(upper_i, fmt_i);
  assign l = field_value(lower_i, fmt_i);
  assign outside_o = (v > u) || (v < l);
endmodule

/* asw_sequencer.sv */
// Converter sequencer with window detect, calibration and AXI4-Lite registers
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module asw_sequencer
  import asw_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // AXI4-Lite write
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Analog core
  input wire logic [OFFSET_W-1:0] CORE_DATA_I,
  output asw_core_s CORE_O,
  output logic ADC_CLK_O,
  // Interrupt request
  output logic IRQ_O
);
  typedef struct packed {
    asw_ctrl0_s ctrl0;
    asw_ctrl1_s ctrl1;
    asw_ctrl2_s ctrl2;
    logic [SAMP_W-1:0] samp;
    logic [DATA_W-1:0] upper;
    logic [DATA_W-1:0] lower;
    logic [DATA_W-1:0] result;
    logic [OFFSET_W-1:0] offset;
    logic pend;
    logic win_flag;
    logic eoc_flag;
    asw_state_e state;
    logic [15:0] cnt;
    logic [7:0] adc_cnt;
    logic [OFFSET_W-1:0] sync1;
    logic [OFFSET_W-1:0] sync2;
    asw_core_s core;
    logic aw_seen;
    logic [AXI_AW-1:0] aw_addr;
    logic w_seen;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] h_len;
    logic [7:0] h_ticks;
  } asw_top_s;

  asw_top_s r;
  asw_top_s n;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  logic [AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic tick;
  logic win_out;
  logic done;
  logic is_conv;
  logic [OFFSET_W-1:0] v14;
  logic [DATA_W-1:0] cand;
  logic [15:0] wake_cyc;
  logic [7:0] conv_len;

  // Read mux, top bit flags an unmapped address
  function automatic logic [32:0] rd_mux(input asw_top_s s, input logic [AXI_AW-1:0] a);
    asw_status_s st;
    st = '0;
    st.busy = s.state != ST_IDLE;
    st.core_pwr = s.core.pwr;
    st.eoc = s.eoc_flag;
    st.win = s.win_flag;
    st.pend = s.pend;
    unique case (a)
      ADDR_CTRL0: return {1'b0, s.ctrl0};
      ADDR_CTRL1: return {1'b0, s.ctrl1};
      ADDR_CTRL2: return {1'b0, s.ctrl2};
      ADDR_SAMPLE: return {1'b0, 32'(s.samp)};
      ADDR_UPPER: return {1'b0, 32'(s.upper)};
      ADDR_LOWER: return {1'b0, 32'(s.lower)};
      ADDR_RESULT: return {1'b0, 32'(s.result)};
      ADDR_OFFSET: return {1'b0, 32'(s.offset)};
      ADDR_STATUS: return {1'b0, st};
      default: return {1'b1, 32'h0};
    endcase
  endfunction

  // Bus handshakes
  assign S_AXI_AWREADY_O = !r.aw_seen && !r.bvalid;
  assign S_AXI_WREADY_O = !r.w_seen && !r.bvalid;
  assign S_AXI_ARREADY_O = !r.rvalid;
  assign aw_hs = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  assign w_hs = S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign ar_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign wr_go = (r.aw_seen || aw_hs) && (r.w_seen || w_hs);
  assign wr_addr = r.aw_seen ? r.aw_addr : S_AXI_AWADDR_I;
  assign wr_data = r.w_seen ? r.w_data : S_AXI_WDATA_I;
  assign wr_strb = r.w_seen ? r.w_strb : S_AXI_WSTRB_I;

  // Registered outputs
  assign S_AXI_BVALID_O = r.bvalid;
  assign S_AXI_BRESP_O = r.bresp;
  assign S_AXI_RVALID_O = r.rvalid;
  assign S_AXI_RDATA_O = r.rdata;
  assign S_AXI_RRESP_O = r.rresp;
  assign CORE_O = r.core;
  assign IRQ_O = r.pend;

  // Phase lengths
  assign conv_len = r.ctrl1.resolution_select ? CONV_CLKS_14 : CONV_CLKS_12;
  assign wake_cyc = (r.ctrl2.ref_buf_auto && r.ctrl2.power_control_reg == PWR_AUTO
                     && WAKE_REF_CYC > WAKE_ADC_CYC) ? WAKE_REF_CYC : WAKE_ADC_CYC;
  assign is_conv = r.ctrl0.start == START_CONV;
  assign done = r.state == ST_CONVERT && r.ctrl0.start != START_IDLE
                && tick && r.adc_cnt == conv_len - 8'h01;

  // Offset applied only for signed data; 12-bit keeps the upper bits
  assign v14 = r.ctrl1.signed_format_select ? r.sync2 - r.offset : r.sync2;
  assign cand = format_result(v14, r.ctrl1);

  asw_prescaler u_div (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .run_i(r.core.pwr),
    .div_sel_i(r.ctrl2.clock_divisor_select),
    .adc_clk_o(ADC_CLK_O),
    .tick_o(tick)
  );

  asw_window u_win (
    .value_i(cand),
    .upper_i(r.upper),
    .lower_i(r.lower),
    .fmt_i(r.ctrl1),
    .outside_o(win_out)
  );

  // Next state: bus slave, then sequencer
  always_comb begin
    logic [32:0] rdw;
    logic [32:0] rdr;
    logic [31:0] m32;
    asw_ctrl0_s c0;
    asw_status_s st;
    n = r;
    rdw = rd_mux(r, wr_addr);
    rdr = rd_mux(r, S_AXI_ARADDR_I);
    m32 = wmerge(rdw[31:0], wr_data, wr_strb);
    c0 = asw_ctrl0_s'(m32);
    st = asw_status_s'(wr_data);
    n.sync1 = CORE_DATA_I;
    n.sync2 = r.sync1;
    if (aw_hs) begin
      n.aw_seen = 1'b1;
      n.aw_addr = S_AXI_AWADDR_I;
    end
    if (w_hs) begin
      n.w_seen = 1'b1;
      n.w_data = S_AXI_WDATA_I;
      n.w_strb = S_AXI_WSTRB_I;
    end
    if (r.bvalid && S_AXI_BREADY_I) n.bvalid = 1'b0;
    if (r.rvalid && S_AXI_RREADY_I) n.rvalid = 1'b0;
    if (ar_hs) begin
      n.rvalid = 1'b1;
      n.rdata = rdr[31:0];
      n.rresp = rdr[32] ? RESP_SLVERR : RESP_OKAY;
    end
    if (wr_go) begin
      n.aw_seen = 1'b0;
      n.w_seen = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = rdw[32] ? RESP_SLVERR : RESP_OKAY;
      unique case (wr_addr)
        ADDR_CTRL0: begin
          c0.zero = '0;
          // While busy the start field only takes 00 (abort)
          if (r.ctrl0.start != START_IDLE && c0.start != START_IDLE) c0.start = r.ctrl0.start;
          n.ctrl0 = c0;
        end
        ADDR_CTRL1: begin
          n.ctrl1 = asw_ctrl1_s'(m32);
          n.ctrl1.zero = '0;
        end
        ADDR_CTRL2: begin
          n.ctrl2 = asw_ctrl2_s'(m32);
          n.ctrl2.zero = '0;
        end
        ADDR_SAMPLE: n.samp = m32[SAMP_W-1:0];
        ADDR_UPPER: n.upper = m32[DATA_W-1:0];
        ADDR_LOWER: n.lower = m32[DATA_W-1:0];
        ADDR_OFFSET: n.offset = m32[OFFSET_W-1:0];
        ADDR_STATUS: begin
          // Write one to clear; hardware sets below win
          if (wr_strb[0] && st.pend) n.pend = 1'b0;
          if (wr_strb[0] && st.win) n.win_flag = 1'b0;
          if (wr_strb[0] && st.eoc) n.eoc_flag = 1'b0;
        end
        default: n.bresp = rdw[32] ? RESP_SLVERR : RESP_OKAY;
      endcase
    end
    // Sequencer
    if (r.state != ST_IDLE && r.ctrl0.start == START_IDLE) begin
      n.state = ST_IDLE;
    end else begin
      unique case (r.state)
        ST_IDLE: begin
          if (r.ctrl0.start != START_IDLE) begin
            n.cnt = 16'h0;
            n.adc_cnt = 8'h00;
            n.state = (r.ctrl2.power_control_reg == PWR_ON) ? ST_SAMPLE : ST_WAKE;
          end
        end
        ST_WAKE: begin
          n.cnt = r.cnt + 16'h1;
          if (r.cnt >= wake_cyc - 16'h1) begin
            n.cnt = 16'h0;
            n.state = ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          // Calibrations share this path and its settings
          n.cnt = r.cnt + 16'h1;
          if (tick) n.adc_cnt = r.adc_cnt + 8'h01;
          if (r.cnt >= SAMPLE_MIN_CYC - 16'h1 && r.adc_cnt >= r.samp) begin
            n.cnt = 16'h0;
            n.adc_cnt = 8'h00;
            n.state = ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (tick) n.adc_cnt = r.adc_cnt + 8'h01;
        end
      endcase
      if (done) begin
        n.eoc_flag = 1'b1;
        if (r.ctrl0.start == START_OFFCAL) begin
          n.offset = r.sync2;
        end else if (r.ctrl0.start == START_GAINCAL) begin
          n.result = DATA_W'(r.sync2);
        end else begin
          n.result = cand;
          if (win_out) begin
            n.win_flag = 1'b1;
            n.pend = 1'b1;
          end
        end
        if (r.ctrl0.irq_sel) n.pend = 1'b1;
        if (is_conv && r.ctrl0.cont_sel) begin
          n.adc_cnt = 8'h00;
          n.state = ST_SAMPLE;
        end else begin
          n.state = ST_IDLE;
          n.ctrl0.start = START_IDLE;
        end
      end
    end
    // Core controls follow the next state
    n.core.pwr = (n.ctrl2.power_control_reg == PWR_ON) || n.state != ST_IDLE;
    n.core.ref_buf = n.ctrl2.ref_buf_auto && (n.ctrl2.power_control_reg != PWR_AUTO || n.state != ST_IDLE);
    n.core.sample = n.state == ST_SAMPLE;
    n.core.convert = n.state == ST_CONVERT;
    n.core.op = n.ctrl0.start;
    // Checking helpers
    n.h_len = (n.state != r.state) ? 16'h0 : r.h_len + 16'h1;
    n.h_ticks = (n.state != r.state) ? 8'h00 : (tick ? r.h_ticks + 8'h01 : r.h_ticks);
  end

  // State register; pending request never cleared by idling
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence s_leave_idle;
    $past(r.state) == ST_IDLE && r.state != ST_IDLE;
  endsequence

  property p_wake;
    s_leave_idle and ($past(r.ctrl2.power_control_reg) != PWR_ON) |-> r.state == ST_WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake-up after idle");

  property p_skip;
    s_leave_idle and ($past(r.ctrl2.power_control_reg) == PWR_ON) |-> r.state == ST_SAMPLE;
  endproperty
  a_skip: assert property (p_skip) else $error("wake-up not skipped");

  property p_samp_min;
    (r.state == ST_CONVERT && $past(r.state) == ST_SAMPLE) |-> $past(r.h_len) >= SAMPLE_MIN_CYC - 16'h1;
  endproperty
  a_samp_min: assert property (p_samp_min) else $error("sampling too short");

  property p_conv_len;
    done |-> r.h_ticks == conv_len - 8'h01
             && r.h_len >= 16'(conv_len - 8'h01) * (16'h2 << r.ctrl2.clock_divisor_select)
             && r.h_len < 16'(conv_len) * (16'h2 << r.ctrl2.clock_divisor_select);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_ref_wake;
    (r.state == ST_SAMPLE && $past(r.state) == ST_WAKE && $past(r.ctrl2.ref_buf_auto)
     && $past(r.ctrl2.power_control_reg) == PWR_AUTO) |-> $past(r.h_len) >= WAKE_REF_CYC - 16'h1;
  endproperty
  a_ref_wake: assert property (p_ref_wake) else $error("reference wake-up too short");

  property p_pwr_down;
    (r.state == ST_IDLE && r.ctrl2.power_control_reg == PWR_AUTO) |-> !CORE_O.pwr;
  endproperty
  a_pwr_down: assert property (p_pwr_down) else $error("core powered while idle");

  sequence s_win_hit;
    done && is_conv && win_out;
  endsequence

  property p_win;
    s_win_hit |=> r.pend && r.win_flag;
  endproperty
  a_win: assert property (p_win) else $error("window event lost");

  property p_no_cmp;
    !done |=> !$rose(r.win_flag);
  endproperty
  a_no_cmp: assert property (p_no_cmp) else $error("window flag without result");

  property p_eoc_irq;
    (done && r.ctrl0.irq_sel) |=> IRQ_O;
  endproperty
  a_eoc_irq: assert property (p_eoc_irq) else $error("end of conversion not raised");

  property p_start_clr;
    (done && !(is_conv && r.ctrl0.cont_sel)) |=> r.ctrl0.start == START_IDLE && r.state == ST_IDLE;
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("start not cleared");

  property p_offcal;
    (done && r.ctrl0.start == START_OFFCAL) |=> r.offset == $past(r.sync2);
  endproperty
  a_offcal: assert property (p_offcal) else $error("offset not stored");
endmodule

/* asw_core_model.sv */
// Behavioural analog core returning a bench-chosen code
`timescale 1ns/1ns
module asw_core_model
  import asw_pkg::*;
(
  // Phase controls from the sequencer
  input wire asw_core_s core_i,
  // Analog level set by the bench
  input wire logic [OFFSET_W-1:0] level_i,
  // Digitised code
  output logic [OFFSET_W-1:0] data_o
);
  // Code only while powered and converting, inverse otherwise
  assign data_o = (core_i.pwr && core_i.convert) ? level_i : ~level_i;
endmodule

/* asw_sequencer_test.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
module asw_sequencer_test
  import asw_pkg::*;
();
  // Bench signals
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [OFFSET_W-1:0] level = 14'h0, core_data;
  logic awrdy, wrdy, bv, arrdy, rv, adc_clk, irq;
  logic [1:0] bresp, rresp, r;
  asw_core_s core;
  int miscompares = 0, checks_done = 0, cycles = 0, pre_n = 0, samp_n = 0, conv_n = 0;

  asw_sequencer DUT (
    .CLK_I(clk), .RESET_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
    .CORE_DATA_I(core_data), .CORE_O(core), .ADC_CLK_O(adc_clk), .IRQ_O(irq)
  );

  asw_core_model core_model (.core_i(core), .level_i(level), .data_o(core_data));

  // System clock, 100 MHz
  initial begin
    forever #5 clk = ~clk;
  end

  // Phase length counters and watchdog
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (core.op != 2'h0 && !core.sample && !core.convert && samp_n == 0) pre_n <= pre_n + 1;
    if (core.sample) samp_n <= samp_n + 1;
    if (core.convert) conv_n <= conv_n + 1;
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end

  // Compare and log
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // Counts and verdict
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // AXI4-Lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
    end while (bv !== 1'h1);
    r = bresp;
    bready <= 1'h0;
    @(posedge clk);
  endtask

  // AXI4-Lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 1'h0;
    end while (rv !== 1'h1);
    v = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge clk);
  endtask

  // Start an operation, poll until the start field is idle
  task automatic run(input logic [31:0] ctl);
    pre_n = 0;
    samp_n = 0;
    conv_n = 0;
    wr(ADDR_CTRL0, ctl);
    do rd(ADDR_CTRL0, d); while (d[1:0] != START_IDLE);
  endtask

  // Reset values, unmapped and read-only places, byte lanes
  task automatic t_reset();
    rd(ADDR_CTRL0, d);
    check("ctrl0", d, 32'h0);
    rd(ADDR_STATUS, d);
    check("status", d, 32'h0);
    check("adc clk off", adc_clk, 1'h0);
    rd(8'h24, d);
    check("unmapped rresp", r, RESP_SLVERR);
    wr(8'h24, 32'h5);
    check("unmapped bresp", r, RESP_SLVERR);
    wr(ADDR_RESULT, 32'h1234);
    rd(ADDR_RESULT, d);
    check("result ro", d, 32'h0);
    wr(ADDR_SAMPLE, 32'hffff_ffaa, 4'h2);
    rd(ADDR_SAMPLE, d);
    check("strobe", d, 32'h0);
  endtask

  // 12-bit, always on, divisor 4
  task automatic t_conv12();
    level <= 14'h2345;
    wr(ADDR_UPPER, 32'hffff);
    wr(ADDR_CTRL2, 32'h11);
    run(32'h5);
    check("no wake", pre_n < 4, 1'h1);
    check("sample min", samp_n >= SAMPLE_MIN_CYC, 1'h1);
    check("conv 12", conv_n >= 49 && conv_n <= 52, 1'h1);
    rd(ADDR_RESULT, d);
    check("result 12", d, 32'h08d1);
    check("core on", core.pwr, 1'h1);
    check("irq end", irq, 1'h1);
    rd(ADDR_STATUS, d);
    check("end only", d[2:0], 3'h5);
  endtask

  // 14-bit with automatic power, then reference buffer wake
  task automatic t_wake();
    wr(ADDR_CTRL2, 32'h0);
    wr(ADDR_CTRL1, 32'h2);
    run(32'h1);
    check("adc wake", pre_n >= WAKE_ADC_CYC && pre_n < WAKE_ADC_CYC + 4, 1'h1);
    check("conv 14", conv_n >= 29 && conv_n <= 32, 1'h1);
    rd(ADDR_RESULT, d);
    check("result 14", d, 32'h2345);
    check("core off", core.pwr, 1'h0);
    wr(ADDR_CTRL2, 32'h20);
    run(32'h1);
    check("ref wake", pre_n >= WAKE_REF_CYC && pre_n < WAKE_REF_CYC + 4, 1'h1);
    check("ref off", core.ref_buf, 1'h0);
  endtask

  // Window source only, reserved threshold bits, no recompare
  task automatic t_window();
    wr(ADDR_CTRL1, 32'h0);
    wr(ADDR_UPPER, 32'h0900);
    wr(ADDR_LOWER, 32'hf100);
    wr(ADDR_STATUS, 32'h1f);
    level <= 14'h2345;
    run(32'h1);
    check("inside", irq, 1'h0);
    level <= 14'h3ffc;
    run(32'h1);
    check("above", irq, 1'h1);
    wr(ADDR_CTRL2, 32'h0);
    repeat (50) @(posedge clk);
    rd(ADDR_STATUS, d);
    check("pending kept", d[1:0], 2'h3);
    wr(ADDR_STATUS, 32'h1f);
    wr(ADDR_UPPER, 32'h0100);
    repeat (3) @(posedge clk);
    check("no recompare", irq, 1'h0);
    level <= 14'h0100;
    run(32'h1);
    check("below", irq, 1'h1);
    wr(ADDR_STATUS, 32'h1f);
    wr(ADDR_CTRL0, 32'h1);
    wr(ADDR_CTRL0, 32'h2);
    rd(ADDR_CTRL0, d);
    check("busy start kept", d[1:0], START_CONV);
    wr(ADDR_CTRL0, 32'h0);
    repeat (3) @(posedge clk);
    rd(ADDR_STATUS, d);
    check("aborted", d[4:0], 5'h0);
  endtask

  // Every start code, calibrations, hardware offset
  task automatic t_cal();
    logic signed [OFFSET_W-1:0] off;
    logic [31:0] gain;
    int sum;
    wr(ADDR_CTRL2, 32'h30);
    check("ref on", core.ref_buf, 1'h1);
    wr(ADDR_SAMPLE, 32'h1e);
    level <= 14'h3ff0;
    for (int c = 1; c < 4; c++) begin
      wr(ADDR_STATUS, 32'h1f);
      run(32'h4 | c);
      check("irq per op", irq, 1'h1);
      check("sample time", samp_n >= 58 && samp_n <= 63, 1'h1);
    end
    rd(ADDR_OFFSET, d);
    off = d[OFFSET_W-1:0];
    check("offset", d, 32'h3ff0);
    rd(ADDR_RESULT, d);
    gain = d;
    check("gain", d, 32'h3ff0);
    level <= 14'h0100;
    wr(ADDR_CTRL1, 32'h6);
    run(32'h1);
    rd(ADDR_RESULT, d);
    check("signed", d, 32'h0110);
    wr(ADDR_CTRL1, 32'h2);
    sum = 0;
    // Two 14-bit results averaged in software
    for (int k = 0; k < 2; k++) begin
      run(32'h1);
      rd(ADDR_RESULT, d);
      check("unsigned", d, 32'h0100);
      sum += int'(d);
    end
    check("average", sum / 2, 32'h0100);
    // Gain scale: full range of 14 bits times three quarters
    check("gain comp", (sum / 2) * ((1 << OFFSET_W) * 3 / 4) / int'(gain), 32'hc0);
    wr(ADDR_OFFSET, 32'h0);
    rd(ADDR_OFFSET, d);
    check("offset cleared", d, 32'h0);
    wr(ADDR_CTRL1, 32'h0);
    run(32'h1);
    rd(ADDR_RESULT, d);
    check("comp 12", int'(d) - int'(off) / 4, 32'h44);
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_conv12();
    t_wake();
    t_window();
    t_cal();
    final_report();
  end
endmodule
